// ---- core/pfgo_defs.vh ----
`ifndef PFGO_DEFS_VH
`define PFGO_DEFS_VH

// register byte offsets
`define PFGO_OFF_F_LATCH 5'h00
`define PFGO_OFF_F_DIR 5'h04
`define PFGO_OFF_F_PINS 5'h08
`define PFGO_OFF_G_LATCH 5'h0c
`define PFGO_OFF_G_DIR 5'h10
`define PFGO_OFF_G_PINS 5'h14
`define PFGO_OFF_CTRL 5'h18

// control register fields
`define PFGO_CTRL_TEST_EN 0
`define PFGO_CTRL_SEG_EN 1
`define PFGO_CTRL_PM_LSB 4
`define PFGO_CTRL_PM_MSB 6

// reset values
`define PFGO_RST_LATCH 8'h00
`define PFGO_RST_DIR 8'h00
`define PFGO_RST_CTRL 8'h00

// segment port mask thresholds
`define PFGO_PM_BIT4 3'h5
`define PFGO_PM_BIT3 3'h6
`define PFGO_PM_BIT10 3'h0

// test controller states
`define PFGO_ST_RESET 4'h0
`define PFGO_ST_IDLE 4'h1
`define PFGO_ST_SEL_DR 4'h2
`define PFGO_ST_CAP_DR 4'h3
`define PFGO_ST_SHIFT_DR 4'h4
`define PFGO_ST_EXIT1_DR 4'h5
`define PFGO_ST_PAUSE_DR 4'h6
`define PFGO_ST_EXIT2_DR 4'h7
`define PFGO_ST_UPD_DR 4'h8
`define PFGO_ST_SEL_IR 4'h9
`define PFGO_ST_CAP_IR 4'ha
`define PFGO_ST_SHIFT_IR 4'hb
`define PFGO_ST_EXIT1_IR 4'hc
`define PFGO_ST_PAUSE_IR 4'hd
`define PFGO_ST_EXIT2_IR 4'he
`define PFGO_ST_UPD_IR 4'hf

// test register width and capture value
`define PFGO_IR_W 4
`define PFGO_IR_CAPTURE 4'h1

`endif

// ---- core/pfgo_tap.v ----
`timescale 1ns/1ps
`include "pfgo_defs.vh"

module pfgo_tap (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // enable and test pins, already synchronised
    input wire enable,
    input wire tck_s,
    input wire tms_s,
    input wire tdi_s,
    // serial output and state
    output reg tdo_q,
    output wire shifting,
    output reg [`PFGO_IR_W-1:0] ir_q
);

    localparam ST_RESET = `PFGO_ST_RESET;
    localparam ST_IDLE = `PFGO_ST_IDLE;
    localparam ST_SEL_DR = `PFGO_ST_SEL_DR;
    localparam ST_CAP_DR = `PFGO_ST_CAP_DR;
    localparam ST_SHIFT_DR = `PFGO_ST_SHIFT_DR;
    localparam ST_EXIT1_DR = `PFGO_ST_EXIT1_DR;
    localparam ST_PAUSE_DR = `PFGO_ST_PAUSE_DR;
    localparam ST_EXIT2_DR = `PFGO_ST_EXIT2_DR;
    localparam ST_UPD_DR = `PFGO_ST_UPD_DR;
    localparam ST_SEL_IR = `PFGO_ST_SEL_IR;
    localparam ST_CAP_IR = `PFGO_ST_CAP_IR;
    localparam ST_SHIFT_IR = `PFGO_ST_SHIFT_IR;
    localparam ST_EXIT1_IR = `PFGO_ST_EXIT1_IR;
    localparam ST_PAUSE_IR = `PFGO_ST_PAUSE_IR;
    localparam ST_EXIT2_IR = `PFGO_ST_EXIT2_IR;
    localparam ST_UPD_IR = `PFGO_ST_UPD_IR;

    reg [3:0] st_q;
    reg [3:0] st_d;
    reg tck_prev_q;
    reg [`PFGO_IR_W-1:0] irsh_q;
    reg bypass_q;
    wire rise;
    wire fall;

    // test clock edges, seen on the system clock
    assign rise = tck_s & ~tck_prev_q;
    assign fall = ~tck_s & tck_prev_q;
    assign shifting = (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);

    // next state from mode select
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RESET: st_d = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: st_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: st_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: st_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: st_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: st_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: st_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
            default: st_d = ST_RESET;
        endcase
    end

    // state, scan registers and serial output on test clock edges
    always @(posedge aclk) begin
        if (!aresetn || !enable) begin
            st_q <= ST_RESET;
            tck_prev_q <= 1'b0;
            irsh_q <= {`PFGO_IR_W{1'b0}};
            ir_q <= {`PFGO_IR_W{1'b0}};
            bypass_q <= 1'b0;
            tdo_q <= 1'b1;
        end else begin
            tck_prev_q <= tck_s;
            if (rise) begin
                st_q <= st_d;
                case (st_q)
                    ST_CAP_IR: irsh_q <= `PFGO_IR_CAPTURE;
                    ST_SHIFT_IR: irsh_q <= {tdi_s, irsh_q[`PFGO_IR_W-1:1]};
                    ST_UPD_IR: ir_q <= irsh_q;
                    ST_CAP_DR: bypass_q <= 1'b0;
                    ST_SHIFT_DR: bypass_q <= tdi_s;
                    default: bypass_q <= bypass_q;
                endcase
            end
            // output changes on the falling test clock edge
            if (fall) begin
                if (st_q == ST_SHIFT_IR)
                    tdo_q <= irsh_q[0];
                else if (st_q == ST_SHIFT_DR)
                    tdo_q <= bypass_q;
            end
        end
    end

endmodule

// ---- core/pfgo_top.v ----
`timescale 1ns/1ps
`include "pfgo_defs.vh"

module pfgo_top #(
    parameter ADDR_W = 5
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // port f pads
    input wire [7:0] pf_in,
    output wire [7:0] pf_out,
    output wire [7:0] pf_oe,
    output wire [7:0] pf_pullup,
    output wire [7:0] pf_in_en,
    // port g pads, five pins
    input wire [4:0] pg_in,
    output wire [4:0] pg_out,
    output wire [4:0] pg_oe,
    output wire [4:0] pg_pullup,
    output wire [4:0] pg_in_en,
    // timer clock inputs
    output wire timer0_ext_clock_in,
    output wire timer1_ext_clock_in,
    // global pullup disable
    input wire pullup_disable
);

    // registers
    reg [7:0] f_latch_q;
    reg [7:0] f_dir_q;
    reg [4:0] g_latch_q;
    reg [4:0] g_dir_q;
    reg test_port_enable_q;
    reg segment_driver_enable_q;
    reg [2:0] segment_port_mask_q;
    reg [7:0] f_sync1_q;
    reg [7:0] f_sync2_q;
    reg [4:0] g_sync1_q;
    reg [4:0] g_sync2_q;
    reg aw_held_q;
    reg w_held_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    // per-pin override signals
    wire [7:0] f_pullup_override_enable;
    wire [7:0] f_pullup_override_value;
    wire [7:0] f_direction_override_enable;
    wire [7:0] f_direction_override_value;
    wire [7:0] f_output_value_override_enable;
    wire [7:0] f_output_value_override_value;
    wire [7:0] f_input_enable_override_enable;
    wire [7:0] f_input_enable_override_value;
    wire [4:0] g_ovr;
    wire [4:0] g_direction_override_value;
    wire [7:0] f_pins;
    wire [4:0] g_pins;
    wire tdo_bit;
    wire shifting;
    wire [`PFGO_IR_W-1:0] ir_bits;
    wire do_write;
    wire [7:0] wbyte;
    wire wsel_ok;

    // two-stage synchronisers on the pads
    always @(posedge aclk) begin
        f_sync1_q <= pf_in;
        f_sync2_q <= f_sync1_q;
        g_sync1_q <= pg_in;
        g_sync2_q <= g_sync1_q;
    end

    // test controller on the test pins
    pfgo_tap u_tap (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(test_port_enable_q),
        .tck_s(f_sync2_q[4]),
        .tms_s(f_sync2_q[5]),
        .tdi_s(f_sync2_q[7]),
        .tdo_q(tdo_bit),
        .shifting(shifting),
        .ir_q(ir_bits)
    );

    // port f upper nibble: test port overrides
    assign f_pullup_override_enable[7:4] = {4{test_port_enable_q}};
    assign f_pullup_override_value[7:4] = 4'hf;
    assign f_direction_override_enable[7:4] = {4{test_port_enable_q}};
    assign f_direction_override_value[7:4] = {1'b0, shifting, 2'b00};
    assign f_output_value_override_enable[7:4] = {1'b0, test_port_enable_q, 2'b00};
    assign f_output_value_override_value[7:4] = {1'b0, tdo_bit, 2'b00};
    assign f_input_enable_override_enable[7:4] = {4{test_port_enable_q}};
    assign f_input_enable_override_value[7:4] = 4'h0;

    // port f lower nibble: no overrides, plain register control
    assign f_pullup_override_enable[3:0] = 4'h0;
    assign f_pullup_override_value[3:0] = 4'h0;
    assign f_direction_override_enable[3:0] = 4'h0;
    assign f_direction_override_value[3:0] = 4'h0;
    assign f_output_value_override_enable[3:0] = 4'h0;
    assign f_output_value_override_value[3:0] = 4'h0;
    assign f_input_enable_override_enable[3:0] = 4'h0;
    assign f_input_enable_override_value[3:0] = 4'h0;

    // port g: segment driver overrides, one enable for pu, dd and die
    assign g_ovr[4] = segment_driver_enable_q & (segment_port_mask_q > `PFGO_PM_BIT4);
    assign g_ovr[3] = segment_driver_enable_q & (segment_port_mask_q > `PFGO_PM_BIT3);
    assign g_ovr[2] = segment_driver_enable_q;
    assign g_ovr[1] = segment_driver_enable_q & (segment_port_mask_q > `PFGO_PM_BIT10);
    assign g_ovr[0] = g_ovr[1];
    assign g_direction_override_value = 5'h10;

    // pad drive, merging overrides with the port registers
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_fpin
            wire pu_reg;
            assign pu_reg = f_latch_q[i] & ~f_dir_q[i] & ~pullup_disable;
            assign pf_pullup[i] = f_pullup_override_enable[i] ? f_pullup_override_value[i] : pu_reg;
            assign pf_oe[i] = f_direction_override_enable[i] ? f_direction_override_value[i] : f_dir_q[i];
            assign pf_out[i] = f_output_value_override_enable[i] ? f_output_value_override_value[i] : f_latch_q[i];
            assign pf_in_en[i] = f_input_enable_override_enable[i] ? f_input_enable_override_value[i] : 1'b1;
            assign f_pins[i] = f_sync2_q[i] & pf_in_en[i];
        end
        for (i = 0; i < 5; i = i + 1) begin : g_gpin
            wire pu_reg;
            assign pu_reg = g_latch_q[i] & ~g_dir_q[i] & ~pullup_disable;
            assign pg_pullup[i] = g_ovr[i] ? 1'b0 : pu_reg;
            assign pg_oe[i] = g_ovr[i] ? g_direction_override_value[i] : g_dir_q[i];
            assign pg_out[i] = g_latch_q[i];
            assign pg_in_en[i] = g_ovr[i] ? 1'b0 : 1'b1;
            assign g_pins[i] = g_sync2_q[i] & pg_in_en[i];
        end
    endgenerate

    // timer clocks through the digital input path
    assign timer0_ext_clock_in = g_pins[4];
    assign timer1_ext_clock_in = g_pins[3];

    // axi write channel capture
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign do_write = aw_held_q & w_held_q;
    assign wbyte = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
    assign wsel_ok = wstrb_q[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_q[4:2])
                    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6: s_axi_bresp <= 2'b00;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            f_latch_q <= `PFGO_RST_LATCH;
            f_dir_q <= `PFGO_RST_DIR;
            g_latch_q <= 5'h00;
            g_dir_q <= 5'h00;
            test_port_enable_q <= 1'b0;
            segment_driver_enable_q <= 1'b0;
            segment_port_mask_q <= 3'h0;
        end else if (do_write && wsel_ok) begin
            case ({awaddr_q[4:2], 2'b00})
                `PFGO_OFF_F_LATCH: f_latch_q <= wbyte;
                `PFGO_OFF_F_DIR: f_dir_q <= wbyte;
                `PFGO_OFF_F_PINS: f_latch_q <= f_latch_q ^ wbyte;
                `PFGO_OFF_G_LATCH: g_latch_q <= wbyte[4:0];
                `PFGO_OFF_G_DIR: g_dir_q <= wbyte[4:0];
                `PFGO_OFF_G_PINS: g_latch_q <= g_latch_q ^ wbyte[4:0];
                `PFGO_OFF_CTRL: begin
                    test_port_enable_q <= wbyte[`PFGO_CTRL_TEST_EN];
                    segment_driver_enable_q <= wbyte[`PFGO_CTRL_SEG_EN];
                    segment_port_mask_q <= wbyte[`PFGO_CTRL_PM_MSB:`PFGO_CTRL_PM_LSB];
                end
                default: f_latch_q <= f_latch_q;
            endcase
        end
    end

    // axi read channel
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case ({s_axi_araddr[4:2], 2'b00})
                `PFGO_OFF_F_LATCH: s_axi_rdata <= {24'h0, f_latch_q};
                `PFGO_OFF_F_DIR: s_axi_rdata <= {24'h0, f_dir_q};
                `PFGO_OFF_F_PINS: s_axi_rdata <= {24'h0, f_pins};
                `PFGO_OFF_G_LATCH: s_axi_rdata <= {27'h0, g_latch_q};
                `PFGO_OFF_G_DIR: s_axi_rdata <= {27'h0, g_dir_q};
                `PFGO_OFF_G_PINS: s_axi_rdata <= {27'h0, g_pins};
                `PFGO_OFF_CTRL: s_axi_rdata <= {20'h0, ir_bits, 1'b0,
                    segment_port_mask_q, 2'b00, segment_driver_enable_q,
                    test_port_enable_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ---- verif/pfgo_pads.sv ----
`timescale 1ns/1ps

module pfgo_pads (
    // clock
    input wire aclk,
    // device pad drive
    input wire [7:0] pf_out,
    input wire [7:0] pf_oe,
    input wire [7:0] pf_pullup,
    input wire [4:0] pg_out,
    input wire [4:0] pg_oe,
    input wire [4:0] pg_pullup,
    // board drivers
    input wire [7:0] drv_f,
    input wire [7:0] val_f,
    input wire [4:0] drv_g,
    input wire [4:0] val_g,
    input wire probe_on,
    // pad levels seen by the device
    output wire [7:0] pf_lvl,
    output wire [4:0] pg_lvl
);
    reg flt_q = 1'b0;
    reg tck_q = 1'b0;
    reg tms_q = 1'b1;
    reg tdi_q = 1'b0;
    wire [7:0] pdrv;
    wire [7:0] pval;
    // probe owns tdi, tms and tck while attached
    assign pdrv = probe_on ? (drv_f | 8'hb0) : drv_f;
    assign pval = probe_on ? {tdi_q, val_f[6], tms_q, tck_q, val_f[3:0]} : val_f;
    // undriven pins without pull-up wander every cycle
    always @(posedge aclk) begin
        flt_q <= ~flt_q;
    end
    // device first, then board, then pull-up, else floating
    assign pf_lvl = (pf_oe & pf_out) | (~pf_oe & pdrv & pval) |
        (~pf_oe & ~pdrv & (pf_pullup | {8{flt_q}}));
    assign pg_lvl = (pg_oe & pg_out) | (~pg_oe & drv_g & val_g) |
        (~pg_oe & ~drv_g & (pg_pullup | {5{flt_q}}));
    // one test clock period; tck stands low between periods
    task step(input t, input d);
        begin
            @(posedge aclk);
            tms_q <= t;
            tdi_q <= d;
            repeat (6) @(posedge aclk);
            tck_q <= 1'b1;
            repeat (6) @(posedge aclk);
            tck_q <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask
endmodule

// ---- verif/pfgo_assertions.sv ----
`timescale 1ns/1ps

module pfgo_assertions (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus handshakes
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // pads
    input wire [7:0] pf_out,
    input wire [7:0] pf_oe,
    input wire [7:0] pf_pullup,
    input wire [7:0] pf_in_en,
    input wire [4:0] pg_in,
    input wire [4:0] pg_oe,
    input wire [4:0] pg_pullup,
    input wire [4:0] pg_in_en,
    input wire timer0_ext_clock_in,
    input wire timer1_ext_clock_in,
    input wire pullup_disable
);
    reg [1:0] up_q;
    // edges since reset release, for the pin synchroniser
    always @(posedge aclk) begin
        if (!aresetn) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_test_pins_forced: assert property (!pf_in_en[4] |-> pf_pullup[7:4] == 4'hf &&
        pf_in_en[7:4] == 4'h0 && (pf_oe & 8'hb0) == 8'h00) else $error("test pins not forced");
    a_f_low_plain: assert property (pf_in_en[3:0] == 4'hf && pf_pullup[3:0] ==
        (pf_out[3:0] & ~pf_oe[3:0] & {4{!pullup_disable}})) else $error("low pins overridden");
    a_seg_pull_off: assert property ((~pg_in_en & pg_pullup) == 5'h00)
        else $error("segment pin pull-up on");
    a_g4_drives: assert property (!pg_in_en[4] |-> pg_oe[4] && !pg_in_en[2])
        else $error("g4 override wrong");
    a_g3_quiet: assert property (!pg_in_en[3] |-> !pg_oe[3] && pg_in_en == 5'h00)
        else $error("g3 override wrong");
    a_seg_nesting: assert property (!pg_in_en[1] |-> !pg_in_en[0] && !pg_in_en[2] &&
        pg_oe[2:0] == 3'h0) else $error("low segment override wrong");
    a_timer_feed: assert property (up_q == 2'h3 |->
        {timer0_ext_clock_in, timer1_ext_clock_in} == ($past(pg_in[4:3], 2) & pg_in_en[4:3]))
        else $error("timer input wrong");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // main scenarios reached
    c_tdo_drive: cover property (pf_oe[6] && !pf_in_en[6]);
    c_seg_full: cover property (!pg_in_en[3]);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind pfgo_top pfgo_assertions chk_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .pf_out(pf_out), .pf_oe(pf_oe), .pf_pullup(pf_pullup), .pf_in_en(pf_in_en),
    .pg_in(pg_in), .pg_oe(pg_oe), .pg_pullup(pg_pullup), .pg_in_en(pg_in_en),
    .timer0_ext_clock_in(timer0_ext_clock_in), .timer1_ext_clock_in(timer1_ext_clock_in),
    .pullup_disable(pullup_disable)
);

// ---- verif/pfgo_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module pfgo_top_tb_top;
    reg aclk;
    reg aresetn = 1'b0;
    reg [4:0] awaddr = 5'h00;
    reg awvalid = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg [4:0] araddr = 5'h00;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    reg pud = 1'b0;
    reg [7:0] drv_f = 8'hff;
    reg [7:0] val_f = 8'h00;
    reg [4:0] drv_g = 5'h1f;
    reg [4:0] val_g = 5'h18;
    reg probe_on = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, timer0, timer1;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pf_lvl, pf_out, pf_oe, pf_pullup, pf_in_en;
    wire [4:0] pg_lvl, pg_out, pg_oe, pg_pullup, pg_in_en;
    int fails = 0;
    int total_checks = 0;
    int m;
    reg [4:0] a;
    reg [2:0] mk;
    reg [4:0] ov;

    pfgo_top dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pf_in(pf_lvl), .pf_out(pf_out), .pf_oe(pf_oe), .pf_pullup(pf_pullup),
        .pf_in_en(pf_in_en), .pg_in(pg_lvl), .pg_out(pg_out), .pg_oe(pg_oe),
        .pg_pullup(pg_pullup), .pg_in_en(pg_in_en), .timer0_ext_clock_in(timer0),
        .timer1_ext_clock_in(timer1), .pullup_disable(pud)
    );
    pfgo_pads pads_u (
        .aclk(aclk), .pf_out(pf_out), .pf_oe(pf_oe), .pf_pullup(pf_pullup),
        .pg_out(pg_out), .pg_oe(pg_oe), .pg_pullup(pg_pullup), .drv_f(drv_f), .val_f(val_f),
        .drv_g(drv_g), .val_g(val_g), .probe_on(probe_on), .pf_lvl(pf_lvl), .pg_lvl(pg_lvl)
    );
    // clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // counts, verdict and end of run
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // bus write: address and data held until each is taken
    task automatic axi_wr(input [4:0] ad, input [31:0] d, input [1:0] er);
        reg pa, pw, ta, tw;
        reg [1:0] r;
        begin
            @(posedge aclk);
            awaddr <= ad;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            while (pa || pw) begin
                @(negedge aclk);
                ta = pa && awready;
                tw = pw && wready;
                @(posedge aclk);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
                pa = pa && !ta;
                pw = pw && !tw;
            end
            do @(negedge aclk); while (!bvalid);
            @(posedge aclk);
            bready <= 1'b1;
            @(negedge aclk);
            r = bresp;
            @(posedge aclk);
            bready <= 1'b0;
            `CHK("bresp", er, r)
        end
    endtask
    // bus read; ready raised late so the answer must stand
    task automatic axi_rd(input [4:0] ad, input [31:0] ed, input [1:0] er);
        reg [31:0] d;
        reg [1:0] r;
        begin
            @(posedge aclk);
            araddr <= ad;
            arvalid <= 1'b1;
            do @(negedge aclk); while (!arready);
            @(posedge aclk);
            arvalid <= 1'b0;
            do @(negedge aclk); while (!rvalid);
            @(posedge aclk);
            rready <= 1'b1;
            @(negedge aclk);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            rready <= 1'b0;
            `CHK("rdata", ed, d)
            `CHK("rresp", er, r)
        end
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        complete_run;
    end
    // test sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (a = 5'h00; a < 5'h18; a = a + 5'h04) begin
            axi_rd(a, (a == 5'h14) ? 32'h18 : 32'h0, 2'h0);
        end
        axi_wr(5'h00, 32'ha5, 2'h0);
        axi_wr(5'h04, 32'h0f, 2'h0);
        drv_f <= 8'hf0;
        val_f <= 8'h30;
        axi_rd(5'h00, 32'ha5, 2'h0);
        axi_rd(5'h04, 32'h0f, 2'h0);
        axi_rd(5'h08, 32'h35, 2'h0);
        `CHK("pf drive", 24'ha50fa0, {pf_out, pf_oe, pf_pullup})
        `CHK("pf in_en", 8'hff, pf_in_en)
        pud <= 1'b1;
        @(negedge aclk);
        `CHK("pull off", 8'h00, pf_pullup)
        @(posedge aclk);
        pud <= 1'b0;
        axi_wr(5'h1c, 32'hff, 2'h2);
        axi_rd(5'h1c, 32'h0, 2'h2);
        axi_wr(5'h0c, 32'h1f, 2'h0);
        // every mask value with the driver on, then mask 7 with it off
        for (m = 0; m < 9; m++) begin
            mk = (m == 8) ? 3'h7 : m[2:0];
            ov = (m == 8) ? 5'h00 : {mk > 3'h5, mk > 3'h6, 1'b1, mk != 3'h0, mk != 3'h0};
            axi_wr(5'h18, {25'h0, mk, 2'h0, m != 8, 1'b0}, 2'h0);
            repeat (3) @(negedge aclk);
            `CHK("pg_in_en", ~ov, pg_in_en)
            `CHK("pg_oe", {ov[4], 4'h0}, pg_oe)
            `CHK("pg_pullup", ~ov, pg_pullup)
            `CHK("pg_out", 5'h1f, pg_out)
            `CHK("timers", ~ov[4:3], {timer0, timer1})
        end
        drv_f <= 8'h00;
        probe_on <= 1'b1;
        axi_wr(5'h18, 32'h1, 2'h0);
        repeat (3) @(negedge aclk);
        `CHK("test pins", 12'h0f0, {pf_in_en[7:4], pf_pullup[7:4], pf_oe[7:4]})
        // reset the controller, then walk to instruction shift
        for (m = 9; m >= 0; m--) begin
            pads_u.step(m > 4 || m == 3 || m == 2, 1'b0);
        end
        `CHK("tdo drive", 2'h3, {pf_oe[6], pf_out[6]})
        for (m = 0; m < 4; m++) begin
            pads_u.step(m == 3, m[0]);
            if (m < 3) `CHK("tdo bit", 1'b0, pf_out[6])
        end
        `CHK("tdo off", 1'b0, pf_oe[6])
        pads_u.step(1'b1, 1'b0);
        pads_u.step(1'b0, 1'b0);
        axi_rd(5'h18, 32'h0a01, 2'h0);
        axi_wr(5'h18, 32'h0, 2'h0);
        repeat (3) @(negedge aclk);
        `CHK("test released", 8'hff, pf_in_en)
        complete_run;
    end
endmodule
